/* File: rtl/fsp_pkg.sv */
// package of constants and types for the frame sync pulse port
package fsp_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ = 250;
  // pulse width limits, microseconds
  localparam int unsigned SHORT_MIN_US = 5;
  localparam int unsigned SHORT_MAX_US = 1000;
  localparam int unsigned LONG_MIN_US = 2000;
  localparam int unsigned LONG_MAX_US = 5000;
  // frame period and tolerance, microseconds
  localparam int unsigned FRAME_US = 10000;
  localparam int unsigned FRAME_TOL_US = 5;
  // regeneration delay ceiling, nanoseconds
  localparam int unsigned MAX_DELAY_NS = 500;
  localparam int unsigned PERIOD_NS = 4;
  // derived cycle counts (least round up, longest round down)
  localparam int unsigned SHORT_MIN_CYC = SHORT_MIN_US * CLK_MHZ;
  localparam int unsigned SHORT_MAX_CYC = SHORT_MAX_US * CLK_MHZ;
  localparam int unsigned LONG_MIN_CYC = LONG_MIN_US * CLK_MHZ;
  localparam int unsigned LONG_MAX_CYC = LONG_MAX_US * CLK_MHZ;
  localparam int unsigned FRAME_MIN_CYC = (FRAME_US - FRAME_TOL_US) * CLK_MHZ;
  localparam int unsigned FRAME_MAX_CYC = (FRAME_US + FRAME_TOL_US) * CLK_MHZ;
  localparam int unsigned MAX_DELAY_CYC = MAX_DELAY_NS / PERIOD_NS;
  // frames per multiframe
  localparam int unsigned FRAMES_PER_MF = 256;
  // number of good periods before input is declared valid
  localparam int unsigned VALID_PERIODS = 2;
  // counter widths and reset values
  localparam int unsigned CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_RST = 22'h000000;
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [1:0] GOOD_RST = 2'h0;
  // lock state machine
  typedef enum logic [2:0] {
    FSP_HUNT = 3'b001,
    FSP_FRAME = 3'b010,
    FSP_MULTI = 3'b100
  } fsp_state_e;
  // timing outputs carried together
  typedef struct packed {
    logic frame_start;
    logic multiframe_start;
    logic frame_lock;
    logic multiframe_lock;
    logic [7:0] frame_number;
  } fsp_timing_s;
endpackage : fsp_pkg

/* File: rtl/fsp_port.sv */
// frame sync pulse input decoder and output regenerator
//
// Summary of operation
// (RULE_01) align timing only after valid input seen
// (RULE_02) regenerate input on output while valid
// (RULE_03) input to output delay within 500 ns
// (RULE_04) 100 Hz pulses, 5 us to 1 ms
// (RULE_05) every 256th pulse is 2 to 5 ms
// (RULE_06) period is frame, 256 periods multiframe
// (RULE_07) frame start at every falling edge
// (RULE_08) multiframe start at long pulse falling edge; code starts only on a long pulse 256 frames after an earlier long pulse
// (RULE_09) reference places multiframe on 64 s boundary
// (RULE_10) ports optional, block may be omitted
// (RULE_11) bad width or spacing invalidates, stops output
// (RULE_12) long pulse must recur every 256 frames
module fsp_port
  import fsp_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CLK_MHZ // clock cycles per microsecond
)
(
  input wire logic clk_in,            // local station clock, 250 MHz
  input wire logic rst_n_in,          // asynchronous reset, active low
  input wire logic sync_in,           // input sync pin, already received off the line
  output logic sync_out,              // regenerated sync pin
  output fsp_timing_s timing_out,     // frame timing toward the station
  output logic [7:0] station_frame_counter_out // local frame number mod 256
);

  // cycle counts at the chosen time scale; hardware keeps the default rate
  localparam int unsigned SHORT_MIN_C = SHORT_MIN_US * CYC_PER_US;
  localparam int unsigned SHORT_MAX_C = SHORT_MAX_US * CYC_PER_US;
  localparam int unsigned LONG_MIN_C = LONG_MIN_US * CYC_PER_US;
  localparam int unsigned LONG_MAX_C = LONG_MAX_US * CYC_PER_US;
  localparam int unsigned FRAME_MIN_C = (FRAME_US - FRAME_TOL_US) * CYC_PER_US;
  localparam int unsigned FRAME_MAX_C = (FRAME_US + FRAME_TOL_US) * CYC_PER_US;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detect

  logic sync_meta;   // first stage, read only by second
  logic sync_s;      // second stage
  logic sync_d;      // delayed copy for edges
  logic rise;        // rising edge seen
  logic fall;        // falling edge seen

  // two flops, then an edge history flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_meta <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_s <= sync_meta;
      sync_d <= sync_s;
    end
  end

  assign rise = sync_s & ~sync_d;
  assign fall = ~sync_s & sync_d;

  ////////////////////////////////////////////////////////////////////////////
  // width classification

  // short pulse width in range
  function automatic logic is_short(input logic [CNT_W-1:0] w);
    is_short = (w >= CNT_W'(SHORT_MIN_C)) && (w <= CNT_W'(SHORT_MAX_C));
  endfunction : is_short

  // long pulse width in range
  function automatic logic is_long(input logic [CNT_W-1:0] w);
    is_long = (w >= CNT_W'(LONG_MIN_C)) && (w <= CNT_W'(LONG_MAX_C));
  endfunction : is_long

  ////////////////////////////////////////////////////////////////////////////
  // measurement and lock state

  fsp_state_e state;             // lock state
  fsp_state_e next_state;
  logic [CNT_W-1:0] width;       // cycles high in current pulse
  logic [CNT_W-1:0] next_width;
  logic [CNT_W-1:0] period;      // cycles since last rising edge
  logic [CNT_W-1:0] next_period;
  logic [1:0] good;              // consecutive good periods
  logic [1:0] next_good;
  logic [7:0] frame;             // frame number mod 256
  logic [7:0] next_frame;
  logic frame_pulse;             // one-cycle frame start
  logic next_frame_pulse;
  logic mf_pulse;                // one-cycle multiframe start
  logic next_mf_pulse;
  logic armed;                   // a long pulse seen since lock, 256 spacing pending
  logic next_armed;
  logic regen;                   // regenerated output level
  logic next_regen;
  logic pulse_ok;                // width of ending pulse acceptable
  logic pulse_long;              // ending pulse is a long one
  logic spacing_ok;              // rising edge spacing acceptable

  always_comb begin
    pulse_long = is_long(width);                          // RULE_05
    pulse_ok = is_short(width) | pulse_long;              // RULE_04
    spacing_ok = (period >= CNT_W'(FRAME_MIN_C)) &&
                 (period <= CNT_W'(FRAME_MAX_C));         // RULE_06
  end

  // next state of counters and lock
  always_comb begin
    next_state = state;
    next_width = width;
    next_period = period;
    next_good = good;
    next_frame = frame;
    next_frame_pulse = 1'b0;
    next_mf_pulse = 1'b0;
    next_armed = armed;
    // period counter saturates when input stalls
    if (rise) begin
      next_period = CNT_W'(1);                            // rise cycle counts as one
    end else if (period != {CNT_W{1'b1}}) begin
      next_period = period + CNT_W'(1);
    end
    // width counter runs while high
    if (rise) begin
      next_width = CNT_W'(1);                             // rise cycle is already high
    end else if (sync_s && width != {CNT_W{1'b1}}) begin
      next_width = width + CNT_W'(1);
    end
    // spacing check on each rising edge
    if (rise) begin
      if (spacing_ok) begin
        if (good != 2'(VALID_PERIODS)) begin
          next_good = good + 2'h1;
        end
      end else if (state != FSP_HUNT) begin
        next_state = FSP_HUNT;                            // RULE_11
        next_good = GOOD_RST;
      end else begin
        next_good = GOOD_RST;
      end
    end
    // silence longer than a frame drops lock
    if (period > CNT_W'(FRAME_MAX_C) && state != FSP_HUNT) begin
      next_state = FSP_HUNT;                              // RULE_11
      next_good = GOOD_RST;
    end
    // a stuck-high pin is also invalid
    if (sync_s && width > CNT_W'(LONG_MAX_C)) begin
      next_state = FSP_HUNT;                              // RULE_11
      next_good = GOOD_RST;
    end
    if (fall) begin
      next_frame = frame + 8'h01;
      if (!pulse_ok) begin
        next_state = FSP_HUNT;                            // RULE_11
        next_good = GOOD_RST;
      end else begin
        case (state)
          FSP_HUNT: begin
            // lock only after enough good spacings
            if (good == 2'(VALID_PERIODS)) begin
              next_state = FSP_FRAME;                     // RULE_01
              next_frame_pulse = 1'b1;                    // RULE_07
              if (pulse_long) begin
                next_frame = FRAME_RST;
                next_armed = 1'b1;                        // RULE_12
              end
            end
          end
          FSP_FRAME: begin
            next_frame_pulse = 1'b1;                      // RULE_07
            if (pulse_long) begin
              // long pulse only at frame 255 confirms lock
              // only a recurrence of an earlier long pulse confirms it
              if (armed && (frame == 8'(FRAMES_PER_MF - 1))) begin
                next_state = FSP_MULTI;                   // RULE_12
                next_mf_pulse = 1'b1;                     // RULE_08
              end
              next_armed = 1'b1;                          // RULE_12
              next_frame = FRAME_RST;
            end
          end
          FSP_MULTI: begin
            next_frame_pulse = 1'b1;                      // RULE_07
            if (pulse_long != (frame == 8'(FRAMES_PER_MF - 1))) begin
              // long pulse misplaced or missing
              next_state = FSP_FRAME;                     // RULE_12
              next_armed = pulse_long;                    // RULE_12
              if (pulse_long) begin
                next_frame = FRAME_RST;
              end
            end else if (pulse_long) begin
              next_mf_pulse = 1'b1;                       // RULE_08
              next_frame = FRAME_RST;
            end
          end
          default: begin
            next_state = FSP_HUNT;
          end
        endcase
      end
    end
    // losing lock forgets any long pulse seen
    if (next_state == FSP_HUNT) begin
      next_armed = 1'b0;                                  // RULE_12
    end
  end

  // register the lock group
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= FSP_HUNT;
      width <= CNT_RST;
      period <= CNT_RST;
      good <= GOOD_RST;
      frame <= FRAME_RST;
      frame_pulse <= 1'b0;
      mf_pulse <= 1'b0;
      armed <= 1'b0;
    end else begin
      state <= next_state;
      width <= next_width;
      period <= next_period;
      good <= next_good;
      frame <= next_frame;
      frame_pulse <= next_frame_pulse;
      mf_pulse <= next_mf_pulse;
      armed <= next_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output regeneration

  // follow the synchronised pin while locked; a few cycles of latency only
  always_comb begin
    next_regen = 1'b0;
    if (next_state != FSP_HUNT) begin
      next_regen = sync_s;                                // RULE_02 RULE_03
    end
  end

  // register the regenerated level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regen <= 1'b0;
    end else begin
      regen <= next_regen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // self-contained pair; nothing else in a station needs it  // RULE_10
  assign sync_out = regen;
  assign station_frame_counter_out = frame;
  // whole struct in one assignment, it is a single variable
  assign timing_out = '{frame_start: frame_pulse,
                        multiframe_start: mf_pulse,
                        frame_lock: (state != FSP_HUNT),
                        multiframe_lock: (state == FSP_MULTI),
                        frame_number: frame};

endmodule : fsp_port

/* File: tb/fsp_port_properties.sv */
// checker of frame sync pulse port timing
module fsp_port_checker
  import fsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire fsp_timing_s timing_out,
  input wire logic [7:0] station_frame_counter_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////
  // input fall, as seen through the synchroniser
  sequence in_fell3;
    $past(sync_in, 4) && !$past(sync_in, 3);
  endsequence
  // a fall that the lock accepts
  sequence locked_fall;
    in_fell3 ##0 timing_out.frame_lock;
  endsequence
  a_lock_on_fall: assert property ($rose(timing_out.frame_lock) |-> in_fell3)
    else $error("lock rose away from a fall");
  a_quiet_unlocked: assert property (!timing_out.frame_lock &&
    !$past(timing_out.frame_lock) |-> !sync_out) else $error("output active unlocked");
  a_copy_locked: assert property (timing_out.frame_lock &&
    $past(timing_out.frame_lock, 3) |-> sync_out == $past(sync_in, 3))
    else $error("output not a delayed copy");
  a_start_every: assert property (locked_fall |-> timing_out.frame_start)
    else $error("frame start missing");
  a_start_cause: assert property (timing_out.frame_start |-> locked_fall)
    else $error("frame start without fall");
  a_number_step: assert property (timing_out.frame_start && $past(timing_out.frame_lock) &&
    timing_out.frame_number != 8'h00 |-> timing_out.frame_number ==
    $past(timing_out.frame_number) + 8'h01) else $error("frame number skipped");
  a_number_hold: assert property (!timing_out.frame_start && timing_out.frame_lock
    |-> $stable(timing_out.frame_number)) else $error("frame number moved");
  a_counter_mirror: assert property (station_frame_counter_out ==
    timing_out.frame_number) else $error("counter copy differs");
  a_mf_zero: assert property (timing_out.multiframe_start |->
    timing_out.frame_start && timing_out.frame_number == 8'h00) else $error("bad mf start");
  a_mf_needs_frame: assert property (timing_out.multiframe_lock |->
    timing_out.frame_lock) else $error("mf lock without lock");
  a_mf_start_lock: assert property (timing_out.multiframe_start |->
    timing_out.multiframe_lock) else $error("mf start without mf lock");
endmodule : fsp_port_checker

bind fsp_port fsp_port_checker i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .sync_in(sync_in), .sync_out(sync_out), .timing_out(timing_out),
  .station_frame_counter_out(station_frame_counter_out));

/* File: tb/fsp_ref.sv */
// reference pulse source driving the sync input
module fsp_ref
  import fsp_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CLK_MHZ // clock cycles per microsecond
)
(
  input wire logic clk_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line_out = 1'b0; // line idles low between pulses
  // one pulse of the given width, then low to the end of the frame period
  task automatic send(input int unsigned w);
    line_out = 1'b1;
    repeat (w) @(posedge clk_in);
    #1 line_out = 1'b0;
    repeat (FRAME_US * CYC_PER_US - w) @(posedge clk_in);
    #1;
  endtask : send
endmodule : fsp_ref

/* File: tb/fsp_port_tb.sv */
// testbench of the frame sync pulse port
module fsp_port_tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // one cycle per microsecond keeps a frame at 10000 cycles
  localparam int unsigned TB_CYC_PER_US = 1;
  localparam int unsigned T_SHORT_MIN = SHORT_MIN_US * TB_CYC_PER_US;
  localparam int unsigned T_SHORT_MAX = SHORT_MAX_US * TB_CYC_PER_US;
  localparam int unsigned T_LONG_MIN = LONG_MIN_US * TB_CYC_PER_US;
  localparam int unsigned T_LONG_MAX = LONG_MAX_US * TB_CYC_PER_US;
  localparam int unsigned T_FRAME = FRAME_US * TB_CYC_PER_US;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0; // reset held at start
  logic sync_in;
  logic sync_out;
  fsp_timing_s timing_out;
  logic [7:0] station_frame_counter_out;
  int fails = 0;
  int checks_done = 0;
  always #2 clk_in = ~clk_in;
  fsp_ref #(.CYC_PER_US(TB_CYC_PER_US)) i_ref (.clk_in(clk_in), .line_out(sync_in));
  fsp_port #(.CYC_PER_US(TB_CYC_PER_US)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sync_in(sync_in),
    .sync_out(sync_out), .timing_out(timing_out),
    .station_frame_counter_out(station_frame_counter_out));
  //////////////////////////////////////////////////////////////////////
  task automatic compare(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic conclude();
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // one whole frame, lock level checked 8 cycles after the pulse width
  task automatic frame(int unsigned w, logic lk);
    fork i_ref.send(w); join_none
    repeat (w + 8) @(posedge clk_in);
    #1;
    compare("frame_lock", 8'(lk), 8'(timing_out.frame_lock));
    wait fork;
  endtask : frame
  // bounded wait for the regenerated level
  task automatic edge_delay(logic v);
    int n;
    n = 0;
    while (sync_out !== v && n < MAX_DELAY_CYC) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    compare("regen_delay", 8'h01, 8'(sync_out === v));
  endtask : edge_delay
  //////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    compare("sync_out", 8'h00, 8'(sync_out));
    compare("frame_lock", 8'h00, 8'(timing_out.frame_lock));
  endtask : test_reset
  task automatic test_lock();
    frame(T_SHORT_MIN + 2, 1'b0);
    frame(T_SHORT_MAX - 2, 1'b0);
    frame(T_SHORT_MIN + 2, 1'b1);
  endtask : test_lock
  task automatic test_long();
    frame(T_LONG_MAX - 2, 1'b1);
    compare("frame_number", 8'h00, station_frame_counter_out);
    compare("multiframe_lock", 8'h00, 8'(timing_out.multiframe_lock));
  endtask : test_long
  task automatic test_regen();
    fork i_ref.send(T_SHORT_MIN + 2); join_none
    edge_delay(1'b1);
    repeat (T_SHORT_MIN - 4) @(posedge clk_in);
    #1;
    compare("sync_out", 8'h01, 8'(sync_out));
    edge_delay(1'b0);
    repeat (8) @(posedge clk_in);
    #1;
    compare("frame_number", 8'h01, station_frame_counter_out);
    wait fork;
  endtask : test_regen
  task automatic test_bad();
    frame(T_SHORT_MAX + T_LONG_MIN / 4, 1'b0);
    compare("sync_out", 8'h00, 8'(sync_out));
  endtask : test_bad
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    test_reset();
    test_lock();
    test_long();
    test_regen();
    test_bad();
    conclude();
  end
  // watchdog over eight frame periods, two more than the tests use
  initial begin
    repeat (8 * T_FRAME) @(posedge clk_in);
    fails++;
    conclude();
  end
endmodule : fsp_port_tb
